// ===== fpfs_core.sv
// Switching-cycle logic: oscillator, sync, duty clamp, fault sequencing, dead time, AXI4-Lite slave
// Functional notes
// [RL1] Overcurrent hiccup only after unbroken 1.25 ms run of overcurrent periods.
// [RL2] Secondary supply undervoltage after regulation: stop, hold off 200 ms.
// [RL3] Overtemperature shuts down and holds both drives low.
// [RL4] Overtemperature clearing restarts with full soft start.
// [RL5] Internal switching frequency programmable 50 kHz to 600 kHz.
// [RL6] On-time ends so duty never exceeds 85 percent, every phase.
// [RL7] Three consecutive clamped periods in soft start start 40 ms hiccup.
// [RL8] Lock to external sync about seven to ten periods after first edge.
// [RL9] Keep internal frequency until sync lock achieved.
// [RL10] Sync only within plus or minus ten percent of programmed frequency.
// [RL11] Sync accepted while switching or before soft start.
// [RL12] Follow dithered sync clock, relocking every cycle.
// [RL13] Unused sync input is tied to primary analog ground externally.
// [RL14] Overvoltage above threshold drives both outputs off immediately.
// [RL15] Overvoltage clear: primary resumes next period, rectifier phases back in. Code keeps primary off that period, resumes one period later.
// [RL16] Overvoltage persisting 200 us enters 200 ms hiccup.
// [RL17] Fixed dead time between primary and rectifier edges, never both on.
// [RL18] Overcurrent hiccup shuts both drives down for 40 ms.
// [RL19] Hiccup timeout expiry begins new soft start.
// [RL20] Rectifier phase in or out moves edges 1.5 ns per microsecond. Code ramps phase-in only; phase-out is immediate on fault or overvoltage.
// [RL21] During hiccup both drives low, further fault triggers ignored.
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
module fpfs_core #(
  parameter int unsigned OCP_RUN = fpfs_pkg::OCP_RUN_CYC,
  parameter int unsigned HICCUP_STD = fpfs_pkg::HICCUP_STD_CYC,
  parameter int unsigned HICCUP_LONG = fpfs_pkg::HICCUP_LONG_CYC,
  parameter int unsigned OV_PERSIST = fpfs_pkg::OV_PERSIST_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire fpfs_pkg::fpfs_fault_t fault_in,
  input wire logic pwm_terminate,
  input wire logic sync_in,
  output fpfs_pkg::fpfs_drive_t drive_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [fpfs_pkg::PW-1:0] khz_to_period(input logic [15:0] khz);
    logic [31:0] p;
    p = (fpfs_pkg::CLK_MHZ * 1000) / ((khz == 16'h0000) ? 32'd1 : {16'h0000, khz});
    return p[fpfs_pkg::PW-1:0];
  endfunction
  function automatic logic [fpfs_pkg::PW-1:0] pct_of(input logic [fpfs_pkg::PW-1:0] v, input int unsigned pc);
    logic [31:0] m;
    m = ({19'h00000, v} * pc) / 100;
    return m[fpfs_pkg::PW-1:0];
  endfunction

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic enable_q;
  logic [15:0] freq_khz_q;
  logic [fpfs_pkg::PW-1:0] int_per_q, use_per_q, sync_per_q, sync_cnt_q, pcnt_q, on_lim;
  logic [3:0] lock_cnt_q;
  logic locked_q, sync_prev_q, sync_seen_q;
  fpfs_pkg::fpfs_state_t state_q;
  logic [fpfs_pkg::CW-1:0] ocp_cnt_q, hic_cnt_q, ov_cnt_q, tick_q;
  logic ocp_hit_q, ocp_prev_q, ov_stop_q, prim_on_q, clamp_hit_q;
  logic [1:0] clamp_run_q;
  logic [fpfs_pkg::PW-1:0] sr_trim_q;
  logic [3:0] dead_cnt_q;
  logic sr_req_q;
  logic [15:0] phase_ps_q;
  logic period_start;
  logic fault_hold;

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic aw_q, w_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= fpfs_pkg::RESP_OKAY;
      enable_q <= 1'b0;
      freq_khz_q <= fpfs_pkg::FREQ_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (aw_q && w_q) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= fpfs_pkg::RESP_OKAY;
        if (awa_q == fpfs_pkg::ADDR_CTRL) begin
          if (ws_q[0]) enable_q <= wd_q[fpfs_pkg::CTRL_EN_BIT];
        end else if (awa_q == fpfs_pkg::ADDR_FREQ) begin
          if (ws_q[1:0] == 2'h3 && wd_q[15:0] >= 16'(fpfs_pkg::FSW_MIN_KHZ)
              && wd_q[15:0] <= 16'(fpfs_pkg::FSW_MAX_KHZ)) begin // RL5
            freq_khz_q <= wd_q[15:0];
          end
        end else if (awa_q != fpfs_pkg::ADDR_STAT && awa_q != fpfs_pkg::ADDR_DUTY
                     && awa_q != fpfs_pkg::ADDR_SPER) begin
          s_axi_bresp <= fpfs_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= fpfs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= fpfs_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        fpfs_pkg::ADDR_CTRL: s_axi_rdata <= {31'h00000000, enable_q};
        fpfs_pkg::ADDR_FREQ: s_axi_rdata <= {16'h0000, freq_khz_q};
        fpfs_pkg::ADDR_DUTY: s_axi_rdata <= {19'h00000, on_lim};
        fpfs_pkg::ADDR_STAT: s_axi_rdata <= {25'h0000000, ov_stop_q, locked_q, sync_seen_q, 1'b0, state_q};
        fpfs_pkg::ADDR_SPER: s_axi_rdata <= {19'h00000, use_per_q};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= fpfs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Oscillator and synchronisation
  // ----------------------------------------
  logic sync_rise, sync_ok;
  assign sync_rise = sync_in && !sync_prev_q;
  assign sync_ok = (sync_cnt_q + 1'b1 >= pct_of(int_per_q, 100 - fpfs_pkg::SYNC_TOL_PCT))
                   && (sync_cnt_q + 1'b1 <= pct_of(int_per_q, 100 + fpfs_pkg::SYNC_TOL_PCT)); // RL10
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_per_q <= '0;
      sync_prev_q <= 1'b0;
      sync_seen_q <= 1'b0;
      sync_cnt_q <= '0;
      sync_per_q <= '0;
      lock_cnt_q <= 4'h0;
      locked_q <= 1'b0;
    end else begin
      int_per_q <= khz_to_period(freq_khz_q); // RL5
      sync_prev_q <= sync_in;
      if (sync_rise) begin // RL11
        sync_seen_q <= 1'b1; // RL8
        sync_cnt_q <= '0;
        if (sync_seen_q && sync_ok) begin
          sync_per_q <= sync_cnt_q + 1'b1; // RL12
          if (lock_cnt_q == 4'(fpfs_pkg::SYNC_LOCK_CNT)) locked_q <= 1'b1; // RL8
          else lock_cnt_q <= lock_cnt_q + 1'b1;
        end else if (sync_seen_q) begin
          lock_cnt_q <= 4'h0; // RL10
          locked_q <= 1'b0;
        end
      end else if (sync_cnt_q == fpfs_pkg::PW'(fpfs_pkg::PER_MAX_CYC)) begin
        sync_seen_q <= 1'b0;
        lock_cnt_q <= 4'h0;
        locked_q <= 1'b0;
      end else begin
        sync_cnt_q <= sync_cnt_q + 1'b1;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pcnt_q <= '0;
      use_per_q <= '0;
    end else if (period_start) begin
      pcnt_q <= '0;
      use_per_q <= locked_q ? sync_per_q : int_per_q; // RL9
    end else begin
      pcnt_q <= pcnt_q + 1'b1;
    end
  end
  assign period_start = locked_q ? (sync_rise || pcnt_q >= pct_of(int_per_q, 100 + fpfs_pkg::SYNC_TOL_PCT))
                                 : (pcnt_q + 1'b1 >= use_per_q); // RL9 RL12
  assign on_lim = pct_of(use_per_q, fpfs_pkg::DUTY_PCT);

  // ----------------------------------------
  // Fault sequencer
  // ----------------------------------------
  logic [fpfs_pkg::CW-1:0] hic_len_q;
  assign fault_hold = state_q == fpfs_pkg::ST_HICCUP || state_q == fpfs_pkg::ST_OTP || state_q == fpfs_pkg::ST_OFF;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= fpfs_pkg::ST_OFF;
      hic_cnt_q <= '0;
      hic_len_q <= '0;
    end else begin
      unique case (state_q)
        fpfs_pkg::ST_OFF: if (enable_q && !fault_in.overtemp) state_q <= fpfs_pkg::ST_SOFT;
        fpfs_pkg::ST_HICCUP: begin
          hic_cnt_q <= hic_cnt_q + 1'b1; // RL21
          if (hic_cnt_q + 1'b1 >= hic_len_q) state_q <= fpfs_pkg::ST_SOFT; // RL19
        end
        fpfs_pkg::ST_OTP: if (!fault_in.overtemp) state_q <= fpfs_pkg::ST_SOFT; // RL4
        fpfs_pkg::ST_SOFT, fpfs_pkg::ST_RUN: begin
          hic_cnt_q <= '0;
          if (!enable_q) state_q <= fpfs_pkg::ST_OFF;
          else if (fault_in.overtemp) state_q <= fpfs_pkg::ST_OTP; // RL3
          else if (state_q == fpfs_pkg::ST_RUN && fault_in.secondary_undervoltage_lockout) begin // RL2
            state_q <= fpfs_pkg::ST_HICCUP;
            hic_len_q <= fpfs_pkg::CW'(HICCUP_LONG);
          end else if (ov_cnt_q >= fpfs_pkg::CW'(OV_PERSIST)) begin // RL16
            state_q <= fpfs_pkg::ST_HICCUP;
            hic_len_q <= fpfs_pkg::CW'(HICCUP_LONG);
          end else if (ocp_cnt_q >= fpfs_pkg::CW'(OCP_RUN)
                       || (state_q == fpfs_pkg::ST_SOFT && clamp_run_q == 2'(fpfs_pkg::SS_CLAMP_RUN))) begin // RL1 RL7
            state_q <= fpfs_pkg::ST_HICCUP;
            hic_len_q <= fpfs_pkg::CW'(HICCUP_STD); // RL18
          end else if (state_q == fpfs_pkg::ST_SOFT && fault_in.softstart_done && fault_in.regulation_reached) begin
            state_q <= fpfs_pkg::ST_RUN;
          end
        end
        default: state_q <= fpfs_pkg::ST_OFF;
      endcase
    end
  end
  // Overcurrent run counter: each period must see overcurrent
  always_ff @(posedge aclk) begin
    if (!aresetn || fault_hold) begin
      ocp_cnt_q <= '0;
      ocp_hit_q <= 1'b0;
    end else begin
      if (period_start) begin
        ocp_hit_q <= fault_in.overcurrent_protection;
        if (!ocp_hit_q && !fault_in.overcurrent_protection) ocp_cnt_q <= '0; // RL1
      end else if (fault_in.overcurrent_protection) begin
        ocp_hit_q <= 1'b1;
      end
      if (ocp_hit_q || fault_in.overcurrent_protection) ocp_cnt_q <= ocp_cnt_q + 1'b1; // RL1
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || fault_hold) begin
      ov_cnt_q <= '0;
      ov_stop_q <= 1'b0;
    end else begin
      ov_cnt_q <= fault_in.overvoltage_sense ? ov_cnt_q + 1'b1 : '0; // RL16
      if (fault_in.overvoltage_sense) ov_stop_q <= 1'b1; // RL14
      else if (period_start) ov_stop_q <= 1'b0; // RL15
    end
  end

  // ----------------------------------------
  // Primary drive with duty clamp
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prim_on_q <= 1'b0;
      clamp_hit_q <= 1'b0;
      clamp_run_q <= 2'h0;
    end else if (fault_hold || ov_stop_q || fault_in.overvoltage_sense) begin // RL3 RL14 RL21
      prim_on_q <= 1'b0;
      clamp_run_q <= 2'h0;
      clamp_hit_q <= 1'b0;
    end else if (period_start) begin
      prim_on_q <= 1'b1;
      clamp_hit_q <= 1'b0;
      if (state_q == fpfs_pkg::ST_SOFT) clamp_run_q <= clamp_hit_q ? clamp_run_q + 1'b1 : 2'h0; // RL7
    end else if (prim_on_q && (pcnt_q + 1'b1 >= on_lim)) begin // RL6
      prim_on_q <= 1'b0;
      clamp_hit_q <= 1'b1;
    end else if (pwm_terminate) begin
      prim_on_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Rectifier phase-in and dead time
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || fault_hold || ov_stop_q) begin
      sr_trim_q <= on_lim; // RL15
      tick_q <= '0;
      phase_ps_q <= 16'h0000;
    end else if (tick_q + 1'b1 >= fpfs_pkg::CW'(fpfs_pkg::PHASE_TICK_CYC)) begin
      tick_q <= '0;
      if (phase_ps_q + 16'(fpfs_pkg::PHASE_STEP_PS) >= 16'(fpfs_pkg::CLK_PS)) begin // RL20
        phase_ps_q <= phase_ps_q + 16'(fpfs_pkg::PHASE_STEP_PS) - 16'(fpfs_pkg::CLK_PS);
        if (sr_trim_q != '0) sr_trim_q <= sr_trim_q - 1'b1;
      end else begin
        phase_ps_q <= phase_ps_q + 16'(fpfs_pkg::PHASE_STEP_PS);
      end
    end else begin
      tick_q <= tick_q + 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_req_q <= 1'b0;
      dead_cnt_q <= 4'h0;
      drive_out <= '0;
    end else begin
      sr_req_q <= !prim_on_q && !fault_hold && !ov_stop_q && !fault_in.overvoltage_sense
                  && ({1'b0, pcnt_q} + {1'b0, sr_trim_q} + (fpfs_pkg::PW + 1)'(fpfs_pkg::DEAD_CYC) + 1'b1
                      < {1'b0, use_per_q}); // RL20
      if (fault_hold || fault_in.overvoltage_sense || ov_stop_q) begin // RL3 RL14 RL21
        drive_out <= '0;
        dead_cnt_q <= 4'h0;
      end else if (prim_on_q || drive_out.primary_drive) begin
        drive_out.rectifier_drive <= 1'b0; // RL17
        drive_out.primary_drive <= prim_on_q && !drive_out.rectifier_drive;
        dead_cnt_q <= 4'h0;
      end else if (dead_cnt_q < 4'(fpfs_pkg::DEAD_CYC)) begin
        dead_cnt_q <= dead_cnt_q + 1'b1; // RL17
        drive_out.rectifier_drive <= 1'b0;
      end else begin
        drive_out.rectifier_drive <= sr_req_q;
      end
    end
  end
endmodule
`default_nettype wire

// ===== fpfs_core_bench.sv
// Self-checking bench for the flyback switching-cycle sequencer
`default_nettype none
module fpfs_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HIC_S = 400;
  localparam int HIC_L = 800;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b1;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b1;
  fpfs_pkg::fpfs_fault_t fault_in = '0;
  logic pwm_terminate;
  logic sync_in;
  fpfs_pkg::fpfs_drive_t drive_out;
  logic [12:0] trip_cyc = 13'h0;
  logic [12:0] sync_per = 13'h0;
  logic [12:0] sync_dith = 13'h0;
  int errors = 0;
  int check_count = 0;
  int cyc = 0;
  int seed = 32'hed175e6e;
  int on_n = 0;
  int on_max = 0;
  int rect_n = 0;
  int rect_max = 0;
  int exp_freq = 250;
  int per;
  int f;
  int fq[$] = '{49, 601, 50, 0, 600};
  logic [31:0] rd;
  logic [1:0] rsp;
  fpfs_core #(.OCP_RUN(50), .HICCUP_STD(HIC_S), .HICCUP_LONG(HIC_L), .OV_PERSIST(20)) u_dut (.*);
  fpfs_stage_model u_stage (.*);
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    on_n <= drive_out.primary_drive ? on_n + 1 : 0;
    if (on_n > on_max) on_max <= on_n;
    rect_n <= drive_out.rectifier_drive ? rect_n + 1 : 0;
    if (rect_n > rect_max) rect_max <= rect_n;
    if (cyc == 60000) begin
      errors++;
      tally_and_finish();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask
  task automatic axi_read(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    check_word(rd, exp);
  endtask
  task automatic set_freq(input int fv);
    axi_write(fpfs_pkg::ADDR_FREQ, 32'(fv));
    if (fv >= fpfs_pkg::FSW_MIN_KHZ && fv <= fpfs_pkg::FSW_MAX_KHZ && fv != exp_freq) begin
      repeat (per + 4) @(posedge aclk);
      exp_freq = fv;
      per = fpfs_pkg::CLK_MHZ * 1000 / exp_freq;
    end
    reg_check(fpfs_pkg::ADDR_FREQ, 32'(exp_freq));
    reg_check(fpfs_pkg::ADDR_SPER, 32'(per));
    reg_check(fpfs_pkg::ADDR_DUTY, 32'(per * fpfs_pkg::DUTY_PCT / 100));
  endtask
  task automatic wait_state(input fpfs_pkg::fpfs_state_t s);
    int n;
    n = 0;
    do begin
      axi_read(fpfs_pkg::ADDR_STAT);
      n++;
    end while (rd[2:0] !== s && n < 1000);
    check_word({29'h0, rd[2:0]}, {29'h0, s});
  endtask
  task automatic hiccup_span(input int len);
    int t0;
    wait_state(fpfs_pkg::ST_HICCUP);
    t0 = cyc;
    repeat (len / 2) @(posedge aclk);
    check_word({30'h0, drive_out}, 32'h0);
    fault_in.overcurrent_protection <= 1'b0;
    fault_in.overvoltage_sense <= 1'b0;
    fault_in.secondary_undervoltage_lockout <= 1'b0;
    do axi_read(fpfs_pkg::ADDR_STAT); while (rd[2:0] === fpfs_pkg::ST_HICCUP && cyc - t0 < 3 * len);
    check_word(32'(cyc - t0 >= len - 8 && cyc - t0 <= len + 8), 32'h1);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reg_check(fpfs_pkg::ADDR_STAT, 32'h0);
    reg_check(fpfs_pkg::ADDR_FREQ, {16'h0, fpfs_pkg::FREQ_RST});
    axi_read(8'h14);
    check_word({30'h0, rsp}, {30'h0, fpfs_pkg::RESP_SLVERR});
    per = fpfs_pkg::CLK_MHZ * 1000 / exp_freq;
    repeat (9) begin
      f = fq.size() > 0 ? fq.pop_front() : $random(seed) & 32'h2ff;
      set_freq(f);
    end
    set_freq(600);
    sync_per <= 13'(per * 13 / 10);
    axi_write(fpfs_pkg::ADDR_CTRL, 32'h1);
    wait_state(fpfs_pkg::ST_HICCUP);
    check_word(32'(on_max), 32'(per * fpfs_pkg::DUTY_PCT / 100));
    check_word({31'h0, rd[5]}, 32'h0);
    trip_cyc <= 13'd100;
    wait_state(fpfs_pkg::ST_SOFT);
    sync_per <= 13'(per);
    repeat (5 * per) @(posedge aclk);
    axi_read(fpfs_pkg::ADDR_STAT);
    check_word({31'h0, rd[5]}, 32'h0);
    sync_dith <= 13'(per / 20);
    repeat (9 * per) @(posedge aclk);
    axi_read(fpfs_pkg::ADDR_STAT);
    check_word({30'h0, rd[5:4]}, 32'h3);
    fault_in.softstart_done <= 1'b1;
    fault_in.regulation_reached <= 1'b1;
    wait_state(fpfs_pkg::ST_RUN);
    fault_in.overvoltage_sense <= 1'b1;
    repeat (10) @(posedge aclk);
    fault_in.overvoltage_sense <= 1'b0;
    repeat (2 * per) @(posedge aclk);
    reg_check(fpfs_pkg::ADDR_STAT, {25'h0, 1'b0, 2'h3, 1'b0, fpfs_pkg::ST_RUN});
    fault_in.overvoltage_sense <= 1'b1;
    hiccup_span(HIC_L);
    wait_state(fpfs_pkg::ST_RUN);
    fault_in.overcurrent_protection <= 1'b1;
    hiccup_span(HIC_S);
    wait_state(fpfs_pkg::ST_RUN);
    fault_in.secondary_undervoltage_lockout <= 1'b1;
    hiccup_span(HIC_L);
    wait_state(fpfs_pkg::ST_RUN);
    fault_in.overtemp <= 1'b1;
    fault_in.softstart_done <= 1'b0;
    wait_state(fpfs_pkg::ST_OTP);
    fault_in.overtemp <= 1'b0;
    wait_state(fpfs_pkg::ST_SOFT);
    trip_cyc <= 13'd4;
    repeat (4 * per) @(posedge aclk);
    check_word(32'(rect_max > 0 && rect_max <= per - per * fpfs_pkg::DUTY_PCT / 100), 32'h1);
    tally_and_finish();
  end
endmodule
bind fpfs_core fpfs_core_properties u_props (.*);
`default_nettype wire

// ===== fpfs_core_properties.sv
// Concurrent checks on the flyback sequencer ports
`default_nettype none
module fpfs_core_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire fpfs_pkg::fpfs_fault_t fault_in,
  input wire logic pwm_terminate,
  input wire fpfs_pkg::fpfs_drive_t drive_out
);
  // ----------------------------------------
  // Idle-gap counters per drive
  // ----------------------------------------
  logic [3:0] pgap_q;
  logic [3:0] rgap_q;
  always_ff @(posedge aclk) begin
    if (!aresetn || drive_out.primary_drive) pgap_q <= 4'h0;
    else if (pgap_q != 4'hf) pgap_q <= pgap_q + 4'h1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || drive_out.rectifier_drive) rgap_q <= 4'h0;
    else if (rgap_q != 4'hf) rgap_q <= rgap_q + 4'h1;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_ov_drives_off: assert property (fault_in.overvoltage_sense |=> drive_out == 2'h0)
    else $error("drives on after overvoltage");
  a_otp_drives_off: assert property (fault_in.overtemp [*3] |-> drive_out == 2'h0)
    else $error("drives on during overtemperature");
  a_drives_exclusive: assert property (!(drive_out.primary_drive && drive_out.rectifier_drive))
    else $error("both drives on");
  a_dead_before_rect: assert property ($rose(drive_out.rectifier_drive) |-> pgap_q >= 4'(fpfs_pkg::DEAD_CYC))
    else $error("rectifier dead time short");
  a_dead_before_prim: assert property ($rose(drive_out.primary_drive) |-> rgap_q >= 4'(fpfs_pkg::DEAD_CYC))
    else $error("primary dead time short");
  a_trip_ends_on: assert property (pwm_terminate |-> ##2 !drive_out.primary_drive)
    else $error("on-time not ended by trip");
  a_write_resp_time: assert property (s_write_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_resp_time: assert property (s_read_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_read_released: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after acceptance");
  a_write_released: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after acceptance");
endmodule
`default_nettype wire

// ===== fpfs_pkg.sv
// Package: constants and carrier types for the flyback switching-cycle sequencer
`default_nettype none
package fpfs_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned OCP_RUN_US = 1250;
  localparam int unsigned OCP_RUN_CYC = OCP_RUN_US * CLK_MHZ;
  localparam int unsigned HICCUP_STD_MS = 40;
  localparam int unsigned HICCUP_STD_CYC = HICCUP_STD_MS * 1000 * CLK_MHZ;
  localparam int unsigned HICCUP_LONG_MS = 200;
  localparam int unsigned HICCUP_LONG_CYC = HICCUP_LONG_MS * 1000 * CLK_MHZ;
  localparam int unsigned OV_PERSIST_US = 200;
  localparam int unsigned OV_PERSIST_CYC = OV_PERSIST_US * CLK_MHZ;
  localparam int unsigned DEAD_NS = 40;
  localparam int unsigned DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PHASE_STEP_PS = 1500;
  localparam int unsigned PHASE_US = 1;
  localparam int unsigned PHASE_TICK_CYC = PHASE_US * CLK_MHZ;
  localparam int unsigned CLK_PS = 1000000 / CLK_MHZ;
  // Oscillator range, kHz
  localparam int unsigned FSW_MIN_KHZ = 50;
  localparam int unsigned FSW_MAX_KHZ = 600;
  localparam int unsigned PER_MAX_CYC = CLK_MHZ * 1000 / FSW_MIN_KHZ;
  localparam int unsigned PER_MIN_CYC = CLK_MHZ * 1000 / FSW_MAX_KHZ;
  localparam int unsigned DUTY_PCT = 85;
  localparam int unsigned SS_CLAMP_RUN = 3;
  localparam int unsigned SYNC_TOL_PCT = 10;
  localparam int unsigned SYNC_LOCK_CNT = 8;
  localparam int unsigned PW = 13;
  localparam int unsigned CW = 27;
  // ----------------------------------------
  // AXI4-Lite register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FREQ = 8'h04;
  localparam logic [7:0] ADDR_DUTY = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_SPER = 8'h10;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [15:0] FREQ_RST = 16'h00fa;
  typedef enum logic [2:0] {ST_OFF, ST_SOFT, ST_RUN, ST_HICCUP, ST_OTP} fpfs_state_t;
  typedef struct packed {
    logic overcurrent_protection;
    logic overtemp;
    logic overvoltage_sense;
    logic secondary_undervoltage_lockout;
    logic regulation_reached;
    logic softstart_done;
  } fpfs_fault_t;
  typedef struct packed {
    logic primary_drive;
    logic rectifier_drive;
  } fpfs_drive_t;
endpackage
`default_nettype wire

// ===== fpfs_stage_model.sv
// Power stage current trip and external sync source model
`default_nettype none
module fpfs_stage_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire fpfs_pkg::fpfs_drive_t drive_out,
  input wire logic [12:0] trip_cyc,
  input wire logic [12:0] sync_per,
  input wire logic [12:0] sync_dith,
  output logic pwm_terminate,
  output logic sync_in
);
  int on_n;
  int s_n;
  logic alt;
  // Current trip after trip_cyc cycles of on-time, never when zero
  always_ff @(posedge aclk) begin
    if (!aresetn || !drive_out.primary_drive) on_n <= 0;
    else on_n <= on_n + 1;
  end
  assign pwm_terminate = trip_cyc != 13'h0 && on_n >= int'(trip_cyc);
  // Sync clock with optional dither, held at ground level when unused
  always_ff @(posedge aclk) begin
    if (!aresetn || sync_per == 13'h0) begin
      s_n <= 0;
      sync_in <= 1'b0;
      alt <= 1'b0;
    end else if (s_n >= int'(sync_per) + (alt ? int'(sync_dith) : 0) - 1) begin
      s_n <= 0;
      sync_in <= 1'b1;
      alt <= !alt;
    end else begin
      s_n <= s_n + 1;
      if (s_n == int'(sync_per) / 2) sync_in <= 1'b0;
    end
  end
endmodule
`default_nettype wire
